// >>> logic/swm_master.sv
`timescale 1ns/1ps
`include "swm_map.svh"
module swm_master (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            irq,
  input  wire logic       line_i,
  output logic            line_o,
  output logic            line_oe
);
  logic [7:0] select_q;
  logic [2:0] cmd_q;
  logic [7:0] tx_buf_q, rx_buf_q, tx_sh_q, rx_sh_q;
  logic [7:0] ien_q, div_q, ctrl_q;
  logic       tbe_q, tx_shift_empty_flag_q, rbf_q, rx_shift_full_flag_q, pdr_q, pd_q;
  logic       sync1_q, line_level_in;
  logic [2:0] pre_cnt_q;
  logic [6:0] div_cnt_q;
  logic       pre_tick, tick;
  swm_pkg::swm_state_e state_q;
  logic [9:0] us_q;
  logic [2:0] bit_q;
  logic       drive_low;
  logic [7:0] flags;
  logic       wr_data, rd_data;
  logic [2:0] sel;

  assign wr_data = sfr_wr && (sfr_addr == `SWM_SFR_DATA);
  assign rd_data = sfr_rd && (sfr_addr == `SWM_SFR_DATA);
  assign sel = select_q[2:0];

  // Synchroniser for the line pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q       <= 1'b1;
      line_level_in <= 1'b1;
    end else begin
      sync1_q       <= line_i;
      line_level_in <= sync1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst)
      select_q <= 8'h00;
    else if (sfr_wr && sfr_addr == `SWM_SFR_SELECT)
      select_q <= sfr_wdata;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ien_q  <= 8'h00;
      div_q  <= 8'h00;
      ctrl_q <= 8'h00;
    end else if (wr_data) begin
      if (sel == `SWM_A_ENABLES) ien_q <= sfr_wdata & `SWM_IEN_MASK;
      if (sel == `SWM_A_DIVIDER) div_q <= sfr_wdata & `SWM_DIV_MASK;
      if (sel == `SWM_A_CONTROL) ctrl_q <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !div_q[`SWM_CLK_EN_BIT])
      pre_cnt_q <= 3'h0;
    else if (pre_tick)
      pre_cnt_q <= 3'h0;
    else
      pre_cnt_q <= pre_cnt_q + 3'h1;
  end
  assign pre_tick = div_q[`SWM_CLK_EN_BIT] &&
                    (pre_cnt_q == {div_q[1:0], 1'b0});

  always_ff @(posedge core_clk) begin
    if (rst || !div_q[`SWM_CLK_EN_BIT])
      div_cnt_q <= 7'h00;
    else if (pre_tick)
      div_cnt_q <= tick ? 7'h00 : div_cnt_q + 7'h01;
  end
  assign tick = pre_tick &&
                (div_cnt_q == 7'((8'h01 << div_q[4:2]) - 8'h01));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= swm_pkg::SWM_IDLE;
      cmd_q   <= 3'h0;
      us_q    <= 10'h000;
      bit_q   <= 3'h0;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      tx_shift_empty_flag_q  <= 1'b1;
      rx_shift_full_flag_q  <= 1'b0;
      pd_q    <= 1'b0;
      pdr_q   <= 1'b1;
    end else begin
      if (wr_data && sel == `SWM_A_COMMAND) begin
        cmd_q[2] <= sfr_wdata[2];
        if (sfr_wdata[0]) begin
          cmd_q[0] <= 1'b1;
          cmd_q[1] <= 1'b0;
        end else
          cmd_q[1] <= sfr_wdata[1];
      end
      unique case (state_q)
        swm_pkg::SWM_IDLE: begin
          us_q <= 10'h000;
          // No timing base while disabled, so nothing may start
          if (cmd_q[0] && div_q[`SWM_CLK_EN_BIT]) begin
            state_q <= swm_pkg::SWM_RESET;
          end else if (!cmd_q[0] && div_q[`SWM_CLK_EN_BIT] && !tbe_q &&
                       !(rbf_q && rx_shift_full_flag_q)) begin
            tx_sh_q <= tx_buf_q;
            tx_shift_empty_flag_q  <= 1'b0;
            bit_q   <= 3'h0;
            rx_shift_full_flag_q  <= 1'b1;
            state_q <= swm_pkg::SWM_BIT;
          end
        end
        swm_pkg::SWM_RESET: if (tick) begin
          us_q <= us_q + 10'h001;
          if (us_q == `SWM_RST_SMP_US + `SWM_RST_LOW_US)
            pdr_q <= ctrl_q[1] ? 1'b0 : line_level_in;
          if (us_q == `SWM_RST_END_US) begin
            cmd_q[0] <= 1'b0;
            pd_q     <= 1'b1;
            state_q  <= swm_pkg::SWM_IDLE;
          end
        end
        swm_pkg::SWM_BIT: if (tick) begin
          us_q <= us_q + 10'h001;
          if (us_q[6:0] == `SWM_SMP_US)
            rx_sh_q <= {line_level_in, rx_sh_q[7:1]};
          if (us_q[6:0] == `SWM_SLOT_US) begin
            us_q    <= 10'h000;
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              tx_shift_empty_flag_q  <= 1'b1;
              rx_shift_full_flag_q  <= rbf_q;
              state_q <= swm_pkg::SWM_IDLE;
            end
          end
        end
        default: state_q <= swm_pkg::SWM_IDLE;
      endcase
      if (rd_data && sel == `SWM_A_FLAGS)
        pd_q <= 1'b0;
    end
  end

  // Bus drive: reset pulse, slot low time, or forced low
  always_comb begin
    drive_low = 1'b0;
    if (state_q == swm_pkg::SWM_RESET)
      drive_low = us_q < `SWM_RST_LOW_US;
    else if (state_q == swm_pkg::SWM_BIT)
      drive_low = us_q[6:0] < (tx_sh_q[0] ? `SWM_W1_LOW_US
                                           : `SWM_W0_LOW_US);
    if (cmd_q[2] && ctrl_q[2])
      drive_low = 1'b1;
  end
  assign line_o  = 1'b0;
  assign line_oe = drive_low;

  // tx buffer load, rx buffer handling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_buf_q <= 8'h00;
      rx_buf_q <= 8'h00;
      tbe_q    <= 1'b1;
      rbf_q    <= 1'b0;
    end else begin
      if (state_q == swm_pkg::SWM_IDLE && !cmd_q[0] && !tbe_q &&
          div_q[`SWM_CLK_EN_BIT] && !(rbf_q && rx_shift_full_flag_q))
        tbe_q <= 1'b1;
      if (wr_data && sel == `SWM_A_BUFFER) begin
        tx_buf_q <= sfr_wdata;
        tbe_q    <= 1'b0;
      end
      if (rd_data && sel == `SWM_A_BUFFER)
        rbf_q <= 1'b0;
      // Set wins over the read clear
      if (state_q == swm_pkg::SWM_BIT && tick && bit_q == 3'h7 &&
          us_q[6:0] == `SWM_SLOT_US && !rbf_q) begin
        rx_buf_q <= rx_sh_q;
        rbf_q    <= 1'b1;
      end
    end
  end

  assign flags = {line_level_in == 1'b0 && state_q == swm_pkg::SWM_IDLE
                  && !drive_low, 1'b0, rx_shift_full_flag_q, rbf_q, tx_shift_empty_flag_q, tbe_q,
                  pdr_q, pd_q};

  always_comb begin
    unique case (sel)
      `SWM_A_COMMAND: sfr_rdata = {4'h0, line_level_in, cmd_q};
      `SWM_A_BUFFER:  sfr_rdata = rx_buf_q;
      `SWM_A_FLAGS:   sfr_rdata = flags;
      `SWM_A_ENABLES: sfr_rdata = ien_q;
      `SWM_A_DIVIDER: sfr_rdata = div_q;
      `SWM_A_CONTROL: sfr_rdata = ctrl_q;
      default:        sfr_rdata = 8'h00;
    endcase
    if (sfr_addr == `SWM_SFR_SELECT)
      sfr_rdata = select_q;
  end

  assign irq = |(flags & ien_q);

  tick_one_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
    tick |=> !tick or (div_q[1:0] == 2'h0 && div_q[4:2] == 3'h0))
    else $error("tick longer than one cycle");
  tick_gated_a: assert property (@(posedge core_clk) disable iff (rst)
    !div_q[7] |-> !tick) else $error("tick while disabled");
  bad_select_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_data && sel > 3'h5 |=> $stable(ien_q) && $stable(div_q))
    else $error("invalid select changed state");
  flag_ro_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_data && sel == 3'h2 |=> $stable(ien_q) && $stable(ctrl_q))
    else $error("flag write had effect");
  tx_load_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_data && sel == 3'h1 |=> !tbe_q && tx_buf_q == $past(sfr_wdata))
    else $error("tx buffer not loaded");
  reset_start_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_data && sel == 3'h0 && sfr_wdata[0] |=> cmd_q[0] && !cmd_q[1])
    else $error("reset command not taken");
  shift_load_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_q == swm_pkg::SWM_BIT) |-> !tx_shift_empty_flag_q && tbe_q)
    else $error("shift load flags wrong");
  irq_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    pd_q && ien_q[0] |-> irq) else $error("irq missing");
endmodule // swm_master

// >>> logic/swm_map.svh
// Summary of operation
// - CPU reaches master via select/data SFRs
// - Low three select bits pick register
// - Data register moves only implemented bits
// - Flag register read-only, others read-write
// - Buffer writes load tx, reads give rx
// - Invalid select ignores writes, reads zero
// - Master sequences all bus timing itself
// - Bus events set flags raising requests
// - All timing from 1 MHz base tick
// - Prescaler divides by 1, 3, 5, 7
// - Divider divides by two to the code
// - Bit 7 enables clock generation
// - Reset command runs reset, reports presence
// - Tx byte moves to shifter, LSB first
// - Rx buffer full sets, clears on read
`ifndef SWM_MAP_SVH
`define SWM_MAP_SVH
`define SWM_SFR_SELECT   8'hee
`define SWM_SFR_DATA     8'hef
`define SWM_A_COMMAND    3'h0
`define SWM_A_BUFFER     3'h1
`define SWM_A_FLAGS      3'h2
`define SWM_A_ENABLES    3'h3
`define SWM_A_DIVIDER    3'h4
`define SWM_A_CONTROL    3'h5
`define SWM_CMD_MASK     8'h07
`define SWM_IEN_MASK     8'hfd
`define SWM_DIV_MASK     8'h9f
`define SWM_CLK_EN_BIT   7
`define SWM_FLAGS_RESET  8'h0e
// Slot timing in microsecond ticks
`define SWM_RST_LOW_US   10'd480
`define SWM_RST_SMP_US   10'd70
`define SWM_RST_END_US   10'd960
`define SWM_SLOT_US      7'd70
`define SWM_W1_LOW_US    7'd6
`define SWM_W0_LOW_US    7'd60
`define SWM_SMP_US       7'd15
`endif

// >>> logic/swm_pkg.sv
package swm_pkg;
  typedef enum logic [1:0] {
    SWM_IDLE,
    SWM_RESET,
    SWM_BIT
  } swm_state_e;
endpackage

// >>> verif/swm_slave_model.sv
`timescale 1ns/1ps
module swm_slave_model (
  input  wire logic       line,
  input  wire logic       present,
  input  wire logic [7:0] rd_byte,
  input  int              us_ns,
  output logic            pull_low,
  output logic [7:0]      wr_byte
);
  realtime t0;
  int      idx;
  initial begin
    pull_low = 1'b0;
    wr_byte  = 8'h00;
    idx      = 0;
  end
  always @(negedge line) begin
    if (!pull_low) begin
      t0 = $realtime;
      pull_low = !rd_byte[idx[2:0]];
      #(30 * us_ns);
      wr_byte  = {line, wr_byte[7:1]};
      pull_low = 1'b0;
      if (line !== 1'b1) @(posedge line);
      idx++;
      // A long low is a bus reset, not a slot
      if ($realtime - t0 > 400 * us_ns) begin
        idx = 0;
        if (present) begin
          #(20 * us_ns) pull_low = 1'b1;
          #(100 * us_ns) pull_low = 1'b0;
        end
      end
    end
  end
endmodule // swm_slave_model

// >>> verif/tb_single_wire_bus_master_host_port.sv
`timescale 1ns/1ps
`include "swm_map.svh"
module tb_single_wire_bus_master_host_port;
  logic core_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, s_b, s_w;
  logic irq, line_o, line_oe, pull_low;
  int n_errors, tests_run, cyc, us = 8, m[8], k, r, c;
  int mk[8] = '{8'h07, 8'hff, 8'hff, 8'hfd, 8'h9f, 8'hff, 0, 0};
  int rat[5] = '{1, 3, 5, 7, 2};
  logic [7:0] cd[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84};
  logic [31:0] xs = 32'd57881;
  logic [7:0] x, d;
  wire line = !(line_oe | pull_low);
  always #4 core_clk = ~core_clk;
  swm_master i_dut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .irq(irq), .line_i(line), .line_o(line_o),
    .line_oe(line_oe));
  swm_slave_model i_slv (.line(line), .present(1'b1), .rd_byte(s_b),
    .us_ns(us), .pull_low(pull_low), .wr_byte(s_w));
  function automatic logic [7:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs[7:0];
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge core_clk);
    sfr_addr  = a;
    sfr_wdata = v;
    sfr_wr    = 1'b1;
    @(negedge core_clk);
    sfr_wr    = 1'b0;
  endtask
  task automatic ir(int a, logic [7:0] v);
    wr(`SWM_SFR_SELECT, a[7:0]);
    wr(`SWM_SFR_DATA, v);
  endtask
  // Read data is combinational, so sample it before the strobe's edge
  task automatic rr(int a, logic [7:0] e);
    wr(`SWM_SFR_SELECT, a[7:0]);
    sfr_addr = `SWM_SFR_DATA;
    sfr_rd   = 1'b1;
    #2 chk($sformatf("reg%0d", a), e, sfr_rdata);
    @(negedge core_clk);
    sfr_rd = 1'b0;
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    s_b = 8'hff;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rr(2, `SWM_FLAGS_RESET);
    rr(0, 8'h08);
    for (r = 3; r < 6; r++) for (k = 0; k < 4; k++) begin
      x = rnd();
      ir(r, x);
      m[r] = x & mk[r];
      rr(r, m[r][7:0]);
      ir(6 + k % 2, ~x);
      rr(6 + k % 2, 8'h00);
      rr(r, m[r][7:0]);
    end
    ir(2, 8'hff);
    rr(2, `SWM_FLAGS_RESET);
    ir(4, 8'h00);
    ir(5, 8'h00);
    ir(3, 8'h04);
    #2 chk("irq_on", 1, irq);
    ir(3, 8'h01);
    #2 chk("irq_off", 0, irq);
    ir(0, 8'h01);
    c = 0;
    repeat (40) @(negedge core_clk) c += line_oe;
    chk("clk_off", 0, c);
    for (k = 0; k < 5; k++) begin
      us = 8 * rat[k];
      ir(4, cd[k]);
      if (k > 0) ir(0, 8'h01);
      for (c = 0; c < 200 && !line_oe; c++) @(negedge core_clk);
      for (c = 0; c < 9000 && line_oe; c++) @(negedge core_clk);
      chk("ratio", 1, (c - 480 * rat[k]) ** 2 <= (rat[k] + 3) ** 2);
      for (c = 0; c < 9000 && !irq; c++) @(negedge core_clk);
      chk("pd_irq", 1, irq);
      rr(2, 8'h0d);
      #2 chk("irq_clr", 0, irq);
      rr(0, 8'h08);
    end
    us = 8;
    ir(4, 8'h80);
    ir(3, 8'h10);
    for (k = 0; k < 2; k++) begin
      s_b = rnd();
      d = k ? 8'hff : rnd();
      ir(1, d);
      for (c = 0; c < 2000 && !irq; c++) @(negedge core_clk);
      chk("slave_rx", d & s_b, s_w);
      rr(1, d & s_b);
      rr(2, 8'h0c);
      #2 chk("rbf_irq", 0, irq);
    end
    end_of_test();
  end
endmodule // tb_single_wire_bus_master_host_port
